// >>> hw/wd_map.svh
`ifndef WD_MAP_SVH
`define WD_MAP_SVH

// Register offsets on the register port
`define WD_OFS_STATUS      8'h00
`define WD_OFS_CONFIG      8'h04

// Status flag positions
`define WD_ST_SLOW_OSC     7
`define WD_ST_PUMP         6
`define WD_ST_OVERVOLT     5
`define WD_ST_UNDERVOLT    4
`define WD_ST_OVERTEMP     3
`define WD_ST_DOG_SYS      2
`define WD_ST_DOG_CPU      1
`define WD_ST_POR          0

// Reset values
`define WD_STATUS_RESET    8'h01
`define WD_CONFIG_RESET    8'h11

// Timing
`define WD_SLOW_KHZ        125
`define WD_BASE_MS         10
`define WD_BASE_TICKS      (`WD_SLOW_KHZ * `WD_BASE_MS)
`define WD_REF_PERIOD_NS   5
`define WD_OSC_LOSS_NS     32000
`define WD_OSC_LOSS_CYCLES (`WD_OSC_LOSS_NS / `WD_REF_PERIOD_NS)
`define WD_CPU_RST_TICKS   8'h10
`define WD_SYS_RST_TICKS   8'h80

`endif

// >>> hw/wd_pkg.sv
package wd_pkg;

    typedef enum logic [1:0] {
        WD_IDLE      = 2'h0,
        WD_CPU_PULSE = 2'h1,
        WD_SYS_PULSE = 2'h3
    } wd_pulse_e;

    typedef struct packed {
        logic       clear_toggle;
        logic [1:0] sys_count;
        logic [2:0] cpu_timeout;
        logic       lock;
        logic       enable;
    } wd_cfg_s;

    typedef struct packed {
        logic pump_voltage;
        logic overvoltage;
        logic undervoltage;
        logic overtemp;
    } wd_fault_s;

endpackage

// >>> hw/wd_supervisor.sv
// Operation
// - Status bit 7 set while the 125kHz slow clock has stopped.
// - Bit 6 set on pump voltage fault during driver use; drivers forced off.
// - Bit 5 set on overvoltage; drivers off when overvoltage protect is 1.
// - Bit 4 set on undervoltage; drivers off when undervoltage protect is 1.
// - Bit 3 set on overtemperature; drivers disabled at the same time.
// - Bit 2 set when the watchdog issued a full system reset.
// - Bit 1 set when the watchdog caused a processor reset.
// - Bit 0 set when the power-on reset caused the system reset.
// - Status flags clear only on written one; zero leaves them unchanged.
// - Watchdog timing is taken from the free-running 125kHz slow clock.
// - Watchdog runs only while enable bit is 1; otherwise no reset.
// - Enabled watchdog makes a 10ms base counted by two post-scalers.
// - Processor post-scaler time-out without clear resets the processor only.
// - After configured consecutive processor resets, reset the whole system.
// - Every change of clear bit clears counter and both post-scalers.
// - With lock set, config writes ignored except the clear bit.
// - Lock clears only at power-on reset; locked enabled dog stays enabled.
// - Disabling the watchdog clears both post-scalers immediately.
// - While enabled, time-out and system count fields cannot change.
// - System reset runs full power-on flow, so longer pulse than processor.
// - Watchdog stops in sleep or standby unless low-power enable is 1.
// - In sleep with system reset enabled, system time-out wakes instead.
// - In standby, processor time-out wakes instead of resetting the processor.
// - System count field: 00 none, 01 every reset, 10 after 4, 11 after 8.
// - Processor time-out field multiplies 10ms base by 2 to the n.
// - After power-on reset: enabled, 160ms time-out, no system reset.
`timescale 1ns/1ps
`default_nettype none
`include "wd_map.svh"

module wd_supervisor #(
    parameter int OSC_LOSS_CYCLES = `WD_OSC_LOSS_CYCLES
) (
    input  wire logic              REF_CLK,
    input  wire logic              RST,
    input  wire logic              SLOW_CLK,
    input  wire logic [7:0]        REG_ADDR,
    input  wire logic              REG_WR,
    input  wire logic              REG_RD,
    input  wire logic [7:0]        REG_WDATA,
    output var  logic [7:0]        REG_RDATA,
    input  wire wd_pkg::wd_fault_s FAULT_IN,
    input  wire logic              DRV_ACTIVE,
    input  wire logic              OVERVOLT_PROTECT,
    input  wire logic              UNDERVOLT_PROTECT,
    input  wire logic              LOWPOWER_DOG_EN,
    input  wire logic              SLEEP_MODE,
    input  wire logic              STANDBY_MODE,
    output var  logic              CPU_RST,
    output var  logic              SYS_RST,
    output var  logic              WAKE,
    output var  logic              DRV_OFF
);
    import wd_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisation
    logic [4:0] sync_q;
    wd_fault_s  fault;

    wd_sync3 #(
        .WIDTH (5)
    ) u_sync (
        .clk (REF_CLK),
        .rst (RST),
        .d   ({SLOW_CLK, FAULT_IN}),
        .q   (sync_q)
    );

    assign fault = wd_fault_s'(sync_q[3:0]);

    logic slow_prev_q;
    wire  slow_now  = sync_q[4];
    wire  slow_tick = slow_now & ~slow_prev_q;
    wire  slow_edge = slow_now ^ slow_prev_q;

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            slow_prev_q <= 1'b0;
        end else begin
            slow_prev_q <= slow_now;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Slow clock loss monitor
    logic [15:0] loss_cnt_q;
    logic [15:0] loss_cnt_d;
    wire         osc_lost = (32'(loss_cnt_q) >= OSC_LOSS_CYCLES);

    assign loss_cnt_d = slow_edge ? 16'h0000 : (osc_lost ? loss_cnt_q : loss_cnt_q + 16'h0001);

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            loss_cnt_q <= 16'h0000;
        end else begin
            loss_cnt_q <= loss_cnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register decode
    wire wr_status = REG_WR && (REG_ADDR == `WD_OFS_STATUS);
    wire wr_config = REG_WR && (REG_ADDR == `WD_OFS_CONFIG);

    ////////////////////////////////////////////////////////////////////////
    // Configuration register
    wd_cfg_s cfg_q;
    wd_cfg_s cfg_d;
    wd_cfg_s cfg_wr;

    assign cfg_wr = wd_cfg_s'(REG_WDATA);

    always_comb begin
        cfg_d = cfg_q;
        if (wr_config) begin
            cfg_d.clear_toggle = cfg_wr.clear_toggle;
            if (!cfg_q.lock) begin
                cfg_d.enable = cfg_wr.enable;
                cfg_d.lock   = cfg_wr.lock;
                if (!cfg_q.enable) begin
                    cfg_d.sys_count   = cfg_wr.sys_count;
                    cfg_d.cpu_timeout = cfg_wr.cpu_timeout;
                end
            end
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            cfg_q <= wd_cfg_s'(`WD_CONFIG_RESET);
        end else begin
            cfg_q <= cfg_d;
        end
    end

    // Service by inverting the clear bit
    wire clear_req = wr_config && (cfg_wr.clear_toggle != cfg_q.clear_toggle);

    ////////////////////////////////////////////////////////////////////////
    // Watchdog counters, all stepped on slow clock rising edges
    wire low_power = SLEEP_MODE | STANDBY_MODE;
    wire dog_run   = cfg_q.enable & (~low_power | LOWPOWER_DOG_EN);

    logic        clr_pend_q;
    logic [10:0] base_q;
    logic [6:0]  cpu_ps_q;
    logic [3:0]  sys_ps_q;
    logic        clr_pend_d;
    logic [10:0] base_d;
    logic [6:0]  cpu_ps_d;
    logic [3:0]  sys_ps_d;

    wire       base_wrap = (base_q == 11'(`WD_BASE_TICKS - 1));
    wire [7:0] cpu_lim   = 8'(8'h01 << cfg_q.cpu_timeout);
    wire       cpu_hit   = base_wrap && ({1'b0, cpu_ps_q} + 8'h01 == cpu_lim);
    wire [3:0] sys_lim   = (cfg_q.sys_count == 2'h1) ? 4'h1 :
                           (cfg_q.sys_count == 2'h2) ? 4'h4 : 4'h8;
    wire       sys_on    = (cfg_q.sys_count != 2'h0);
    wire       sys_hit   = sys_on && (sys_ps_q + 4'h1 >= sys_lim);
    wire       timeout   = dog_run && slow_tick && !clr_pend_q && cpu_hit;

    always_comb begin
        clr_pend_d = clr_pend_q;
        base_d     = base_q;
        cpu_ps_d   = cpu_ps_q;
        sys_ps_d   = sys_ps_q;
        if (!dog_run) begin
            clr_pend_d = 1'b0;
            base_d     = 11'h000;
            cpu_ps_d   = 7'h00;
            sys_ps_d   = 4'h0;
        end else if (slow_tick) begin
            if (clr_pend_q) begin
                clr_pend_d = 1'b0;
                base_d     = 11'h000;
                cpu_ps_d   = 7'h00;
                sys_ps_d   = 4'h0;
            end else if (base_wrap) begin
                base_d = 11'h000;
                if (cpu_hit) begin
                    cpu_ps_d = 7'h00;
                    sys_ps_d = sys_hit ? 4'h0 : sys_ps_q + 4'h1;
                end else begin
                    cpu_ps_d = cpu_ps_q + 7'h01;
                end
            end else begin
                base_d = base_q + 11'h001;
            end
        end
        // A request in the tick cycle still lands on the next tick
        if (clear_req && dog_run) begin
            clr_pend_d = 1'b1;
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            clr_pend_q <= 1'b0;
            base_q     <= 11'h000;
            cpu_ps_q   <= 7'h00;
            sys_ps_q   <= 4'h0;
        end else begin
            clr_pend_q <= clr_pend_d;
            base_q     <= base_d;
            cpu_ps_q   <= cpu_ps_d;
            sys_ps_q   <= sys_ps_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Time-out routing: reset in normal mode, wake-up in standby, or in sleep on a system time-out
    wire go_wake = timeout && (STANDBY_MODE || (SLEEP_MODE && sys_hit));
    wire go_sys  = timeout && !low_power && sys_hit;
    wire go_cpu  = timeout && !low_power;

    ////////////////////////////////////////////////////////////////////////
    // Reset pulse generator
    // Pulse length counts slow ticks, so it stalls if the slow clock dies
    wd_pulse_e  pulse_q;
    wd_pulse_e  pulse_d;
    logic [7:0] pulse_cnt_q;
    logic [7:0] pulse_cnt_d;
    logic       wake_q;

    always_comb begin
        pulse_d     = pulse_q;
        pulse_cnt_d = pulse_cnt_q;
        case (pulse_q)
            WD_IDLE: begin
                if (go_sys) begin
                    pulse_d     = WD_SYS_PULSE;
                    pulse_cnt_d = `WD_SYS_RST_TICKS;
                end else if (go_cpu) begin
                    pulse_d     = WD_CPU_PULSE;
                    pulse_cnt_d = `WD_CPU_RST_TICKS;
                end
            end
            WD_CPU_PULSE, WD_SYS_PULSE: begin
                if (go_sys) begin
                    pulse_d     = WD_SYS_PULSE;
                    pulse_cnt_d = `WD_SYS_RST_TICKS;
                end else if (slow_tick) begin
                    if (pulse_cnt_q == 8'h01) begin
                        pulse_d = WD_IDLE;
                    end
                    pulse_cnt_d = pulse_cnt_q - 8'h01;
                end
            end
            default: begin
                pulse_d     = WD_IDLE;
                pulse_cnt_d = 8'h00;
            end
        endcase
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            pulse_q     <= WD_IDLE;
            pulse_cnt_q <= 8'h00;
            wake_q      <= 1'b0;
        end else begin
            pulse_q     <= pulse_d;
            pulse_cnt_q <= pulse_cnt_d;
            wake_q      <= go_wake;
        end
    end

    // A system reset also holds the processor in reset
    assign CPU_RST = (pulse_q != WD_IDLE);
    assign SYS_RST = (pulse_q == WD_SYS_PULSE);
    assign WAKE    = wake_q;

    ////////////////////////////////////////////////////////////////////////
    // Reset and fault status flags, set wins over a write-one clear
    logic [7:0] status_q;
    logic [7:0] status_set;
    wire  [7:0] status_clr = wr_status ? REG_WDATA : 8'h00;

    always_comb begin
        status_set = 8'h00;
        status_set[`WD_ST_SLOW_OSC]  = osc_lost;
        status_set[`WD_ST_PUMP]      = fault.pump_voltage & DRV_ACTIVE;
        status_set[`WD_ST_OVERVOLT]  = fault.overvoltage;
        status_set[`WD_ST_UNDERVOLT] = fault.undervoltage;
        status_set[`WD_ST_OVERTEMP]  = fault.overtemp;
        status_set[`WD_ST_DOG_SYS]   = go_sys;
        status_set[`WD_ST_DOG_CPU]   = go_cpu;
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            status_q <= `WD_STATUS_RESET;
        end else begin
            status_q <= (status_q & ~status_clr) | status_set;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Driver shut-down
    logic drv_off_q;
    wire  drv_off_d = status_q[`WD_ST_PUMP]
                    | (status_q[`WD_ST_OVERVOLT] & OVERVOLT_PROTECT)
                    | (status_q[`WD_ST_UNDERVOLT] & UNDERVOLT_PROTECT)
                    | status_q[`WD_ST_OVERTEMP] | fault.overtemp;

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            drv_off_q <= 1'b0;
        end else begin
            drv_off_q <= drv_off_d;
        end
    end

    assign DRV_OFF = drv_off_q;

    ////////////////////////////////////////////////////////////////////////
    // Read data
    wire [7:0] rd_mux = (REG_ADDR == `WD_OFS_STATUS) ? status_q :
                        (REG_ADDR == `WD_OFS_CONFIG) ? 8'(cfg_q) : 8'h00;

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            REG_RDATA <= 8'h00;
        end else if (REG_RD) begin
            REG_RDATA <= rd_mux;
        end
    end

endmodule

`default_nettype wire

// >>> hw/wd_sync3.sv
`timescale 1ns/1ps
`default_nettype none

module wd_sync3 #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] d,
    output var  logic [WIDTH-1:0] q
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            logic s1_q;
            logic s2_q;
            logic s3_q;
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                    s3_q <= 1'b0;
                    q[i] <= 1'b0;
                end else begin
                    s1_q <= d[i];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    // Accept a new level only once two stages agree
                    if (s2_q == s3_q) begin
                        q[i] <= s3_q;
                    end
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

// >>> sim/wd_host_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "wd_map.svh"

module wd_host_model (
    input  wire logic       clk,
    input  wire logic [7:0] rdata,
    output var  logic [7:0] addr,
    output var  logic       wr_en,
    output var  logic       rd_en,
    output var  logic [7:0] wdata
);
    initial begin
        addr  = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
        wdata = 8'h00;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr  = a;
        wdata = d;
        wr_en = 1'b1;
        @(negedge clk);
        wr_en = 1'b0;
        // Released data shows no stale value
        wdata = ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        addr  = a;
        rd_en = 1'b1;
        @(negedge clk);
        rd_en = 1'b0;
        d     = rdata;
    endtask

    // Read, flip the clear bit, write back
    task automatic service();
        logic [7:0] c;
        rd(`WD_OFS_CONFIG, c);
        wr(`WD_OFS_CONFIG, c ^ 8'h80);
    endtask
endmodule
`default_nettype wire

// >>> sim/wd_supervisor_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "wd_map.svh"

module wd_supervisor_assertions #(
    parameter int OSC_LOSS_CYCLES = 6400
) (
    input wire logic              REF_CLK,
    input wire logic              RST,
    input wire logic              SLOW_CLK,
    input wire logic [7:0]        REG_ADDR,
    input wire logic              REG_RD,
    input wire logic [7:0]        REG_RDATA,
    input wire wd_pkg::wd_fault_s FAULT_IN,
    input wire logic              DRV_ACTIVE,
    input wire logic              CPU_RST,
    input wire logic              SYS_RST,
    input wire logic              DRV_OFF
);
    import wd_pkg::*;

    logic [1:0]  slow_q;
    logic [7:0]  ticks_q;
    logic [15:0] gap_q;
    wire         edge_w = slow_q[0] & ~slow_q[1];
    wire         st_rd  = REG_RD && (REG_ADDR == `WD_OFS_STATUS);

    // Pulse length in slow ticks, so the check holds for any slow rate
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            slow_q  <= 2'h0;
            ticks_q <= 8'h00;
            gap_q   <= 16'h0000;
        end else begin
            slow_q  <= {slow_q[0], SLOW_CLK};
            ticks_q <= !CPU_RST ? 8'h00 : ticks_q + 8'(edge_w);
            gap_q   <= edge_w ? 16'h0000 : gap_q + 16'(gap_q != 16'hffff);
        end
    end

    default clocking dcb @(posedge REF_CLK);
    endclocking
    default disable iff (RST);

    ////////////////////////////////////////////////////////////////////////
    AST_SYS_WITH_CPU: assert property (SYS_RST |-> CPU_RST)
        else $error("system reset without cpu reset");
    AST_CPU_PULSE: assert property ($fell(CPU_RST) && !$past(SYS_RST) |-> ticks_q inside {[15:17]})
        else $error("cpu reset pulse length wrong");
    AST_SYS_PULSE: assert property ($fell(SYS_RST) |-> ticks_q inside {[127:129]})
        else $error("system reset pulse length wrong");
    AST_OT_DRV: assert property ((FAULT_IN.overtemp)[*8] |-> DRV_OFF)
        else $error("drivers on during overtemp");
    AST_PUMP_DRV: assert property ((FAULT_IN.pump_voltage && DRV_ACTIVE)[*8] |-> DRV_OFF)
        else $error("drivers on during pump fault");
    AST_OT_FLAG: assert property ((FAULT_IN.overtemp)[*8] ##0 st_rd |=> REG_RDATA[`WD_ST_OVERTEMP])
        else $error("overtemp flag missing");
    AST_OV_FLAG: assert property ((FAULT_IN.overvoltage)[*8] ##0 st_rd |=> REG_RDATA[`WD_ST_OVERVOLT])
        else $error("overvoltage flag missing");
    AST_UV_FLAG: assert property ((FAULT_IN.undervoltage)[*8] ##0 st_rd |=> REG_RDATA[`WD_ST_UNDERVOLT])
        else $error("undervoltage flag missing");
    // Margin covers a trailing falling edge and the longer design filter
    AST_OSC_FLAG: assert property (gap_q > OSC_LOSS_CYCLES + 40 && st_rd |=> REG_RDATA[`WD_ST_SLOW_OSC])
        else $error("slow clock loss not flagged");

    cover property ($fell(CPU_RST) && !$past(SYS_RST));
    cover property ($fell(SYS_RST));
    cover property ($rose(DRV_OFF));
endmodule

bind wd_supervisor wd_supervisor_assertions #(.OSC_LOSS_CYCLES(OSC_LOSS_CYCLES)) i_chk (
    .REF_CLK(REF_CLK), .RST(RST), .SLOW_CLK(SLOW_CLK), .REG_ADDR(REG_ADDR), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .FAULT_IN(FAULT_IN), .DRV_ACTIVE(DRV_ACTIVE), .CPU_RST(CPU_RST),
    .SYS_RST(SYS_RST), .DRV_OFF(DRV_OFF)
);
`default_nettype wire

// >>> sim/wd_supervisor_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "wd_map.svh"

module wd_supervisor_bench;
    import wd_pkg::*;

    localparam int LOSS  = 500;
    localparam int SLOWC = 125 / `WD_REF_PERIOD_NS;
    localparam int BASEC = `WD_BASE_TICKS * SLOWC;
    // Three full time-outs dominate, about 98k cycles
    localparam int LIMIT = 100000;

    logic       REF_CLK = 1'b0;
    logic       SLOW_CLK = 1'b0;
    logic       RST = 1'b1;
    logic       slow_run = 1'b1;
    logic       DRV_ACTIVE = 1'b1;
    logic       OVERVOLT_PROTECT = 1'b1;
    logic       UNDERVOLT_PROTECT = 1'b1;
    logic       LOWPOWER_DOG_EN = 1'b0;
    logic       SLEEP_MODE = 1'b0;
    logic       STANDBY_MODE = 1'b0;
    wd_fault_s  FAULT_IN = '0;
    logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA;
    logic       REG_WR, REG_RD, CPU_RST, SYS_RST, WAKE, DRV_OFF;
    int         miscompares = 0;
    int         tests_run = 0;
    int         cycles = 0;

    always #2.5 REF_CLK = ~REF_CLK;
    // Offset keeps slow edges away from the sampling edge
    initial begin
        #1.1;
        forever #62.5 SLOW_CLK = slow_run ? ~SLOW_CLK : SLOW_CLK;
    end

    wd_supervisor #(.OSC_LOSS_CYCLES(LOSS)) i_dut (
        .REF_CLK(REF_CLK), .RST(RST), .SLOW_CLK(SLOW_CLK), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
        .REG_RD(REG_RD), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .FAULT_IN(FAULT_IN),
        .DRV_ACTIVE(DRV_ACTIVE), .OVERVOLT_PROTECT(OVERVOLT_PROTECT),
        .UNDERVOLT_PROTECT(UNDERVOLT_PROTECT), .LOWPOWER_DOG_EN(LOWPOWER_DOG_EN),
        .SLEEP_MODE(SLEEP_MODE), .STANDBY_MODE(STANDBY_MODE), .CPU_RST(CPU_RST),
        .SYS_RST(SYS_RST), .WAKE(WAKE), .DRV_OFF(DRV_OFF)
    );
    wd_host_model i_host (
        .clk(REF_CLK), .rdata(REG_RDATA), .addr(REG_ADDR), .wr_en(REG_WR), .rd_en(REG_RD),
        .wdata(REG_WDATA)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        if (miscompares == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        i_host.rd(a, d);
        chk(d, exp);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge REF_CLK);
    endtask

    task automatic wait_lvl(input bit sys, input logic lvl, input int lim, output int n);
        n = 0;
        while (((sys ? SYS_RST : CPU_RST) !== lvl) && n < lim) begin
            @(negedge REF_CLK);
            n++;
        end
    endtask

    task automatic rst_pulse(input int n);
        @(negedge REF_CLK);
        RST = 1'b1;
        cyc(n);
        RST = 1'b0;
    endtask

    always @(posedge REF_CLK) begin
        cycles++;
        if (cycles == LIMIT) begin
            miscompares++;
            finish_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        int n;
        int i;
        rst_pulse(12);
        rchk(`WD_OFS_STATUS, `WD_STATUS_RESET);
        rchk(`WD_OFS_CONFIG, `WD_CONFIG_RESET);
        rchk(8'h08, 8'h00);
        i_host.wr(`WD_OFS_STATUS, 8'h00);
        rchk(`WD_OFS_STATUS, 8'h01);
        i_host.wr(`WD_OFS_STATUS, 8'h01);
        rchk(`WD_OFS_STATUS, 8'h00);
        i_host.wr(`WD_OFS_CONFIG, 8'h01);
        rchk(`WD_OFS_CONFIG, 8'h11);
        slow_run = 1'b0;
        cyc(LOSS + 600);
        rchk(`WD_OFS_STATUS, 8'h80);
        slow_run = 1'b1;
        cyc(200);
        i_host.wr(`WD_OFS_STATUS, 8'h80);
        rchk(`WD_OFS_STATUS, 8'h00);
        for (i = 0; i < 4; i++) begin
            FAULT_IN = wd_fault_s'(4'h1 << i);
            cyc(10);
            rchk(`WD_OFS_STATUS, 8'h08 << i);
            chk({7'h00, DRV_OFF}, 8'h01);
            i_host.wr(`WD_OFS_STATUS, 8'hff);
            rchk(`WD_OFS_STATUS, 8'h08 << i);
            FAULT_IN = '0;
            cyc(10);
            i_host.wr(`WD_OFS_STATUS, 8'hff);
            rchk(`WD_OFS_STATUS, 8'h00);
            chk({7'h00, DRV_OFF}, 8'h00);
        end
        DRV_ACTIVE = 1'b0;
        FAULT_IN = wd_fault_s'(4'h8);
        cyc(10);
        rchk(`WD_OFS_STATUS, 8'h00);
        FAULT_IN = '0;
        // Let the filtered pump fault drain before drivers count as active
        cyc(10);
        DRV_ACTIVE = 1'b1;
        OVERVOLT_PROTECT = 1'b0;
        UNDERVOLT_PROTECT = 1'b0;
        for (i = 1; i < 3; i++) begin
            FAULT_IN = wd_fault_s'(4'h1 << i);
            cyc(10);
            chk({7'h00, DRV_OFF}, 8'h00);
            FAULT_IN = '0;
            cyc(10);
            i_host.wr(`WD_OFS_STATUS, 8'hff);
        end
        i_host.wr(`WD_OFS_CONFIG, 8'h00);
        rchk(`WD_OFS_CONFIG, 8'h10);
        i_host.wr(`WD_OFS_CONFIG, 8'h01);
        rchk(`WD_OFS_CONFIG, 8'h01);
        cyc(2000);
        i_host.service();
        wait_lvl(1'b0, 1'b1, BASEC + 200, n);
        chk(8'(n > BASEC - 20 && n < BASEC + 80), 8'h01);
        chk({7'h00, SYS_RST}, 8'h00);
        wait_lvl(1'b0, 1'b0, 1000, n);
        chk(8'(n > 15 * SLOWC && n < 17 * SLOWC), 8'h01);
        rchk(`WD_OFS_STATUS, 8'h02);
        i_host.wr(`WD_OFS_STATUS, 8'hff);
        i_host.wr(`WD_OFS_CONFIG, 8'h80);
        rchk(`WD_OFS_CONFIG, 8'h80);
        i_host.wr(`WD_OFS_CONFIG, 8'ha1);
        wait_lvl(1'b1, 1'b1, BASEC + 200, n);
        // First slow tick after enabling may come at any phase
        chk(8'(n > BASEC - SLOWC - 20 && n < BASEC + 80), 8'h01);
        chk({7'h00, CPU_RST}, 8'h01);
        wait_lvl(1'b1, 1'b0, 5000, n);
        chk(8'(n > 127 * SLOWC && n < 129 * SLOWC), 8'h01);
        rchk(`WD_OFS_STATUS, 8'h06);
        i_host.wr(`WD_OFS_STATUS, 8'hff);
        LOWPOWER_DOG_EN = 1'b1;
        STANDBY_MODE = 1'b1;
        n = 0;
        while (WAKE !== 1'b1 && n < BASEC) begin
            @(negedge REF_CLK);
            n++;
        end
        chk(8'(n > BASEC - 129 * SLOWC - 40 && n < BASEC - 127 * SLOWC), 8'h01);
        chk({6'h00, CPU_RST, WAKE}, 8'h01);
        cyc(1);
        chk({7'h00, WAKE}, 8'h00);
        rchk(`WD_OFS_STATUS, 8'h00);
        STANDBY_MODE = 1'b0;
        LOWPOWER_DOG_EN = 1'b0;
        rst_pulse(3);
        rchk(`WD_OFS_CONFIG, `WD_CONFIG_RESET);
        i_host.wr(`WD_OFS_CONFIG, 8'h13);
        i_host.wr(`WD_OFS_CONFIG, 8'h00);
        rchk(`WD_OFS_CONFIG, 8'h13);
        i_host.wr(`WD_OFS_CONFIG, 8'h90);
        rchk(`WD_OFS_CONFIG, 8'h93);
        rst_pulse(3);
        rchk(`WD_OFS_CONFIG, `WD_CONFIG_RESET);
        rchk(`WD_OFS_STATUS, `WD_STATUS_RESET);
        finish_test();
    end
endmodule
`default_nettype wire
